// File: logic/cff_pkg.sv
// Package of constants and types for the coprocessor and feature flag control block.
package cff_pkg;

   // ****************************************************************
   // Register selection
   // ****************************************************************
   typedef enum logic [1:0] {
      CFF_SEL_SYS  = 2'h0,
      CFF_SEL_PDB  = 2'h1,
      CFF_SEL_FEAT = 2'h2,
      CFF_SEL_NONE = 2'h3
   } cff_sel_t;

   // ****************************************************************
   // Flag positions in system_control_flags
   // ****************************************************************
   localparam int CFF_PROTECTED_MODE_ON = 0;
   localparam int CFF_MONITOR_COPROCESSOR = 1;
   localparam int CFF_NO_FPU_PRESENT = 2;
   localparam int CFF_TASK_SWITCHED = 3;
   localparam int CFF_CACHE_OFF = 30;
   localparam int CFF_PAGING_ON = 31;

   // ****************************************************************
   // Flag positions in page_directory_base
   // ****************************************************************
   localparam int CFF_DIR_WRITE_THROUGH = 3;
   localparam int CFF_DIR_CACHE_OFF = 4;

   // ****************************************************************
   // Flag positions in feature_extension_flags
   // ****************************************************************
   localparam int CFF_V86_EXTENSIONS = 0;
   localparam int CFF_PROTMODE_VIRTUAL_IRQ = 1;
   localparam int CFF_TIMESTAMP_PRIV_ONLY = 2;
   localparam int CFF_DBG_REG_TRAP = 3;
   localparam int CFF_LARGE_PAGE_ON = 4;
   localparam int CFF_WIDE_PHYS_ADDR = 5;
   localparam int CFF_MACHINE_CHECK_ON = 6;
   localparam int CFF_GLOBAL_PAGE_ON = 7;
   localparam int CFF_PERFCTR_USER_OK = 8;

   // ****************************************************************
   // Reset values and writable masks
   // ****************************************************************
   localparam logic [31:0] CFF_SYS_RESET = 32'h0000_0000;
   localparam logic [31:0] CFF_PDB_RESET = 32'h0000_0000;
   localparam logic [31:0] CFF_FEAT_RESET = 32'h0000_0000;
   localparam logic [31:0] CFF_SYS_WMASK = 32'hc000_000f;
   localparam logic [31:0] CFF_PDB_WMASK = 32'hffff_f018;
   localparam logic [31:0] CFF_FEAT_WMASK = 32'h0000_01ff;

   // ****************************************************************
   // Instruction classes presented by decode
   // ****************************************************************
   typedef enum logic [3:0] {
      CFF_OP_OTHER,
      CFF_OP_FLOAT,
      CFF_OP_FPU_WAIT,
      CFF_OP_INT_SIMD,
      CFF_OP_STREAM_SIMD,
      CFF_OP_SIMD_EXEMPT,
      CFF_OP_CLEAR_TASK_FLAG,
      CFF_OP_READ_TIMESTAMP,
      CFF_OP_READ_PERFCTR,
      CFF_OP_DEBUG_ALIAS,
      CFF_OP_CTRL_REG
   } cff_op_t;

   // ****************************************************************
   // Verdict encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      CFF_V_EXECUTE,
      CFF_V_DEV_UNAVAIL,
      CFF_V_INVALID_OP,
      CFF_V_GEN_PROT
   } cff_verdict_t;

   localparam logic [1:0] CFF_PRIV_KERNEL = 2'h0;
   localparam logic [5:0] CFF_PA_BITS_NARROW = 6'h20;
   localparam logic [5:0] CFF_PA_BITS_WIDE = 6'h24;

endpackage : cff_pkg

// File: logic/cff_ctrl.sv
// Control-flag logic deciding execution or fault for coprocessor and feature-gated ops.
//
// Functional notes
// RL1: Completed hardware task switch sets task_switched.
// RL2: task_switched with FPU present faults float and SIMD ops, exempt ops excluded.
// RL3: Wait faults only when monitor_coprocessor and task_switched are both set.
// RL4: no_fpu_present faults every non-wait float op as device unavailable.
// RL5: no_fpu_present makes integer packed-SIMD ops invalid opcodes.
// RL6: no_fpu_present makes streaming-SIMD ops invalid; exempt ops still execute.
// RL7: No float or SIMD state is saved on a task switch.
// RL8: clear_task_flag_op clears task_switched.
// RL9: protected_mode_on selects protected mode; paging needs both flags.
// RL10: dir_cache_off blocks directory caching unless paging off or cache_off.
// RL11: dir_write_through picks write-through, ignored when paging off or cache_off.
// RL12: v86_extensions enables virtual-8086 redirection and virtual interrupt flag.
// RL13: protmode_virtual_irq enables virtual interrupt flag in protected mode.
// RL14: timestamp_priv_only restricts timestamp reads to privilege level zero.
// RL15: dbg_reg_trap faults alias debug references, else they alias.
// RL16: large_page_on allows large pages, else only 4 KByte pages.
// RL17: wide_phys_addr widens physical addresses and gates long mode.
// RL18: Machine-check exception delivered only with machine_check_on.
// RL19: global_page_on keeps global TLB entries across task switch and base write.
// RL20: Software enables paging_on before global_page_on.
// RL21: perfctr_user_ok lets counter reads run at any privilege level.
// RL22: Setting paging_on with protected_mode_on clear is a protection fault.
// RL23: cache_off is bit 30 and masks the directory cache flags.
// RL24: Faults use flag values at decode; writes affect following instructions.
`timescale 1ns/100ps
`default_nettype none

module cff_ctrl (
   input wire logic clk_sys,                 // Core clock.
   input wire logic rst,                     // Synchronous reset, active high.
   input wire logic cr_wr_en,                // Control register write strobe.
   input wire cff_pkg::cff_sel_t cr_wr_sel,  // Register written.
   input wire logic [31:0] cr_wr_data,       // Write data.
   input wire cff_pkg::cff_sel_t cr_rd_sel,  // Register read.
   output logic [31:0] cr_rd_data,           // Read data, one cycle later.
   output logic cr_wr_fault,                 // Write refused with protection fault.
   input wire logic task_switch_done,        // Hardware task switch completed.
   input wire logic dec_valid,               // Decoded instruction present.
   input wire cff_pkg::cff_op_t dec_op,      // Class of decoded instruction.
   input wire logic [1:0] dec_priv,          // Current privilege level.
   input wire logic mce_event,               // Machine-check condition raised.
   output logic verdict_valid,               // Verdict present.
   output cff_pkg::cff_verdict_t verdict,    // Execute or which fault.
   output logic mce_deliver,                 // Machine-check exception delivered.
   output logic protected_mode,              // Protected operation selected.
   output logic paging_active,               // Paging in effect.
   output logic dir_cache_allowed,           // Directory may be cached internally.
   output logic dir_write_through_en,        // Directory caching is write-through.
   output logic v86_ext_en,                  // Virtual-8086 extensions active.
   output logic pm_virq_en,                  // Protected-mode virtual interrupts.
   output logic large_page_en,               // Large pages allowed.
   output logic [5:0] phys_addr_bits,        // Physical address width.
   output logic long_mode_allowed,           // Long mode may be enabled.
   output logic tlb_flush,                   // TLB flush pulse.
   output logic tlb_keep_global              // Global entries survive the flush.
);
   import cff_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [31:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   function automatic logic priv_ok(input logic restricted, input logic [1:0] lvl);
      priv_ok = !restricted || (lvl == CFF_PRIV_KERNEL);
   endfunction : priv_ok

   // The directory cache flags count only while paging runs with caching allowed.
   function automatic logic dir_flags_live(input logic pg_on, input logic cd_on);
      dir_flags_live = pg_on && !cd_on;
   endfunction : dir_flags_live

   // ****************************************************************
   // State
   // ****************************************************************
   logic [31:0] sys_reg, sys_next;
   logic [31:0] pdb_reg, pdb_next;
   logic [31:0] feat_reg, feat_next;
   logic [31:0] rd_reg, rd_next;
   logic wr_fault_reg, wr_fault_next;
   logic vvalid_reg, vvalid_next;
   cff_verdict_t verdict_reg, verdict_next;
   logic mce_reg, mce_next;
   logic flush_reg, flush_next;
   logic keep_reg, keep_next;
   logic prot_reg, prot_next;
   logic pg_reg, pg_next;
   logic dcache_reg, dcache_next;
   logic dwt_reg, dwt_next;
   logic v86_reg, v86_next;
   logic pvi_reg, pvi_next;
   logic lpg_reg, lpg_next;
   logic [5:0] pab_reg, pab_next;
   logic lma_reg, lma_next;

   logic ts, em, mp, pe, pg, cd;

   always_comb begin
      ts = sys_reg[CFF_TASK_SWITCHED];
      em = sys_reg[CFF_NO_FPU_PRESENT];
      mp = sys_reg[CFF_MONITOR_COPROCESSOR];
      pe = sys_reg[CFF_PROTECTED_MODE_ON];
      pg = sys_reg[CFF_PAGING_ON];
      cd = sys_reg[CFF_CACHE_OFF];
   end

   // ****************************************************************
   // Next-state computation
   // ****************************************************************
   always_comb begin
      sys_next = sys_reg;
      pdb_next = pdb_reg;
      feat_next = feat_reg;
      wr_fault_next = 1'b0;
      flush_next = 1'b0;
      keep_next = keep_reg;
      // Register writes take effect for the instruction after the write.
      if (cr_wr_en) begin
         case (cr_wr_sel)
            CFF_SEL_SYS: begin
               if (cr_wr_data[CFF_PAGING_ON] && !cr_wr_data[CFF_PROTECTED_MODE_ON]) begin
                  wr_fault_next = 1'b1; // see RL22
               end else begin
                  sys_next = merge(sys_reg, cr_wr_data, CFF_SYS_WMASK);
               end
            end
            CFF_SEL_PDB: begin
               pdb_next = merge(pdb_reg, cr_wr_data, CFF_PDB_WMASK);
               flush_next = 1'b1; // see RL19
            end
            CFF_SEL_FEAT: feat_next = merge(feat_reg, cr_wr_data, CFF_FEAT_WMASK);
            default: ;
         endcase
      end
      // Clearing by the instruction loses to a task switch in the same cycle.
      if (dec_valid && dec_op == CFF_OP_CLEAR_TASK_FLAG) begin
         sys_next[CFF_TASK_SWITCHED] = 1'b0; // see RL8
      end
      // The flag is set and a TLB flush raised; float and SIMD state is left for the handler.
      if (task_switch_done) begin
         sys_next[CFF_TASK_SWITCHED] = 1'b1; // see RL1, RL7
         flush_next = 1'b1; // see RL19
      end
      if (flush_next) begin
         keep_next = feat_reg[CFF_GLOBAL_PAGE_ON]; // see RL19
      end
   end

   always_comb begin
      // Verdicts use the flags registered before this decode.
      vvalid_next = dec_valid; // see RL24
      verdict_next = CFF_V_EXECUTE;
      case (dec_op)
         CFF_OP_FLOAT: begin
            if (em || ts) begin
               verdict_next = CFF_V_DEV_UNAVAIL; // see RL2, RL4
            end
         end
         CFF_OP_FPU_WAIT: begin
            if (mp && ts) begin
               verdict_next = CFF_V_DEV_UNAVAIL; // see RL3
            end
         end
         CFF_OP_INT_SIMD, CFF_OP_STREAM_SIMD: begin
            if (em) begin
               verdict_next = CFF_V_INVALID_OP; // see RL5, RL6
            end else if (ts) begin
               verdict_next = CFF_V_DEV_UNAVAIL; // see RL2
            end
         end
         CFF_OP_SIMD_EXEMPT: verdict_next = CFF_V_EXECUTE; // see RL2, RL6
         CFF_OP_READ_TIMESTAMP: begin
            if (!priv_ok(feat_reg[CFF_TIMESTAMP_PRIV_ONLY], dec_priv)) begin
               verdict_next = CFF_V_GEN_PROT; // see RL14
            end
         end
         CFF_OP_READ_PERFCTR: begin
            if (!priv_ok(!feat_reg[CFF_PERFCTR_USER_OK], dec_priv)) begin
               verdict_next = CFF_V_GEN_PROT; // see RL21
            end
         end
         CFF_OP_DEBUG_ALIAS: begin
            if (feat_reg[CFF_DBG_REG_TRAP]) begin
               verdict_next = CFF_V_INVALID_OP; // see RL15
            end
         end
         CFF_OP_CLEAR_TASK_FLAG, CFF_OP_CTRL_REG: begin
            if (pe && !priv_ok(1'b1, dec_priv)) begin
               verdict_next = CFF_V_GEN_PROT;
            end
         end
         default: verdict_next = CFF_V_EXECUTE;
      endcase

      mce_next = mce_event && feat_reg[CFF_MACHINE_CHECK_ON]; // see RL18
   end

   always_comb begin
      // Mode outputs follow the registered flags.
      prot_next = pe; // see RL9
      pg_next = pe && pg; // see RL9
      dcache_next = !(dir_flags_live(pg, cd) && pdb_reg[CFF_DIR_CACHE_OFF]); // see RL10, RL23
      dwt_next = dir_flags_live(pg, cd) && pdb_reg[CFF_DIR_WRITE_THROUGH]; // see RL11, RL23
      v86_next = feat_reg[CFF_V86_EXTENSIONS]; // see RL12
      pvi_next = feat_reg[CFF_PROTMODE_VIRTUAL_IRQ]; // see RL13
      lpg_next = feat_reg[CFF_LARGE_PAGE_ON]; // see RL16
      pab_next = feat_reg[CFF_WIDE_PHYS_ADDR] ? CFF_PA_BITS_WIDE : CFF_PA_BITS_NARROW; // see RL17
      lma_next = feat_reg[CFF_WIDE_PHYS_ADDR]; // see RL17

      case (cr_rd_sel)
         CFF_SEL_SYS: rd_next = sys_reg;
         CFF_SEL_PDB: rd_next = pdb_reg;
         CFF_SEL_FEAT: rd_next = feat_reg;
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sys_reg <= CFF_SYS_RESET;
         pdb_reg <= CFF_PDB_RESET;
         feat_reg <= CFF_FEAT_RESET;
         wr_fault_reg <= 1'b0;
         flush_reg <= 1'b0;
         keep_reg <= 1'b0;
      end else begin
         sys_reg <= sys_next;
         pdb_reg <= pdb_next;
         feat_reg <= feat_next;
         wr_fault_reg <= wr_fault_next;
         flush_reg <= flush_next;
         keep_reg <= keep_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         vvalid_reg <= 1'b0;
         verdict_reg <= CFF_V_EXECUTE;
         mce_reg <= 1'b0;
      end else begin
         vvalid_reg <= vvalid_next;
         verdict_reg <= verdict_next;
         mce_reg <= mce_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_reg <= 32'h0000_0000;
         prot_reg <= 1'b0;
         pg_reg <= 1'b0;
         dcache_reg <= 1'b1;
         dwt_reg <= 1'b0;
         v86_reg <= 1'b0;
         pvi_reg <= 1'b0;
         lpg_reg <= 1'b0;
         pab_reg <= CFF_PA_BITS_NARROW;
         lma_reg <= 1'b0;
      end else begin
         rd_reg <= rd_next;
         prot_reg <= prot_next;
         pg_reg <= pg_next;
         dcache_reg <= dcache_next;
         dwt_reg <= dwt_next;
         v86_reg <= v86_next;
         pvi_reg <= pvi_next;
         lpg_reg <= lpg_next;
         pab_reg <= pab_next;
         lma_reg <= lma_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign cr_rd_data = rd_reg;
   assign cr_wr_fault = wr_fault_reg;
   assign verdict_valid = vvalid_reg;
   assign verdict = verdict_reg;
   assign mce_deliver = mce_reg;
   assign protected_mode = prot_reg;
   assign paging_active = pg_reg;
   assign dir_cache_allowed = dcache_reg;
   assign dir_write_through_en = dwt_reg;
   assign v86_ext_en = v86_reg;
   assign pm_virq_en = pvi_reg;
   assign large_page_en = lpg_reg;
   assign phys_addr_bits = pab_reg;
   assign long_mode_allowed = lma_reg;
   assign tlb_flush = flush_reg;
   assign tlb_keep_global = keep_reg;

endmodule : cff_ctrl

`default_nettype wire

// File: sim/cff_decode_model.sv
// Behavioural model of the decode pipeline that presents instructions to the block.
`timescale 1ns/100ps
`default_nettype none
module cff_decode_model
   import cff_pkg::*;
(
   input wire logic clk_sys, // Core clock.
   input wire logic req_valid, // Instruction to present next cycle.
   input wire cff_pkg::cff_op_t req_op, // Its class.
   input wire logic [1:0] req_priv, // Its privilege level.
   output logic dec_valid, // Decoded instruction present.
   output cff_pkg::cff_op_t dec_op, // Decoded class.
   output logic [1:0] dec_priv // Current privilege level.
);
   // Idle cycles show a changing class and level so that stale values are never trusted.
   always_ff @(posedge clk_sys) begin
      dec_valid <= req_valid;
      dec_op <= req_valid ? req_op : cff_op_t'(4'(req_op) ^ 4'h1);
      dec_priv <= req_valid ? req_priv : ~req_priv;
   end
endmodule : cff_decode_model
`default_nettype wire

// File: sim/cff_ctrl_monitor.sv
// Concurrent checks on the ports of the control flag block.
`timescale 1ns/100ps
`default_nettype none
module cff_ctrl_monitor
   import cff_pkg::*;
(
   input wire logic clk_sys, // Core clock.
   input wire logic rst, // Synchronous reset.
   input wire logic cr_wr_en, // Write strobe.
   input wire cff_pkg::cff_sel_t cr_wr_sel, // Register written.
   input wire logic [31:0] cr_wr_data, // Write data.
   input wire cff_pkg::cff_sel_t cr_rd_sel, // Register read.
   input wire logic [31:0] cr_rd_data, // Read data.
   input wire logic cr_wr_fault, // Refused write.
   input wire logic task_switch_done, // Task switch completed.
   input wire logic dec_valid, // Decode present.
   input wire cff_pkg::cff_op_t dec_op, // Decoded class.
   input wire logic mce_event, // Machine-check condition.
   input wire logic verdict_valid, // Verdict present.
   input wire cff_pkg::cff_verdict_t verdict, // Verdict.
   input wire logic mce_deliver, // Machine-check delivered.
   input wire logic protected_mode, // Protected operation.
   input wire logic paging_active, // Paging in effect.
   input wire logic [5:0] phys_addr_bits, // Physical address width.
   input wire logic long_mode_allowed, // Long mode may be enabled.
   input wire logic tlb_flush // Flush pulse.
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_verdict_follows; dec_valid |=> verdict_valid; endproperty
   a_verdict_follows: assert property (p_verdict_follows)
      else $error("verdict missing after decode");
   property p_wait_kind;
      dec_valid && dec_op == CFF_OP_FPU_WAIT |=> verdict inside {CFF_V_EXECUTE, CFF_V_DEV_UNAVAIL};
   endproperty
   a_wait_kind: assert property (p_wait_kind)
      else $error("wait gave a wrong fault kind");
   property p_paging_needs_pe; paging_active |-> protected_mode; endproperty
   a_paging_needs_pe: assert property (p_paging_needs_pe)
      else $error("paging active outside protected mode");
   property p_addr_width;
      phys_addr_bits == (long_mode_allowed ? CFF_PA_BITS_WIDE : CFF_PA_BITS_NARROW);
   endproperty
   a_addr_width: assert property (p_addr_width)
      else $error("address width disagrees with extension flag");
   property p_mce_cause; mce_deliver |-> $past(mce_event); endproperty
   a_mce_cause: assert property (p_mce_cause)
      else $error("machine check delivered without cause");
   property p_wr_fault;
      cr_wr_en && cr_wr_sel == CFF_SEL_SYS && cr_wr_data[31] && !cr_wr_data[0] |=> cr_wr_fault;
   endproperty
   a_wr_fault: assert property (p_wr_fault)
      else $error("paging without protection not refused");
   property p_flush;
      task_switch_done || (cr_wr_en && cr_wr_sel == CFF_SEL_PDB) |=> tlb_flush;
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush missing");
   property p_ts_set;
      task_switch_done ##1 (cr_rd_sel == CFF_SEL_SYS) |=> cr_rd_data[CFF_TASK_SWITCHED];
   endproperty
   a_ts_set: assert property (p_ts_set)
      else $error("task switched flag not set");
   property p_ts_clear;
      dec_valid && dec_op == CFF_OP_CLEAR_TASK_FLAG && !task_switch_done && !cr_wr_en
         ##1 (cr_rd_sel == CFF_SEL_SYS) |=> !cr_rd_data[CFF_TASK_SWITCHED];
   endproperty
   a_ts_clear: assert property (p_ts_clear)
      else $error("task switched flag not cleared");
endmodule : cff_ctrl_monitor

bind cff_ctrl cff_ctrl_monitor u_mon (.clk_sys, .rst, .cr_wr_en, .cr_wr_sel, .cr_wr_data,
   .cr_rd_sel, .cr_rd_data, .cr_wr_fault, .task_switch_done, .dec_valid, .dec_op, .mce_event,
   .verdict_valid, .verdict, .mce_deliver, .protected_mode, .paging_active, .phys_addr_bits,
   .long_mode_allowed, .tlb_flush);
`default_nettype wire

// File: sim/coproc_and_feature_flag_control_test.sv
// Self-checking bench for the coprocessor and feature flag control block.
`timescale 1ns/100ps
`default_nettype none
module coproc_and_feature_flag_control_test;
   import cff_pkg::*;
   logic clk_sys, rst, cr_wr_en, tsw, mce_event, req_valid, cr_wr_fault, dec_valid;
   logic verdict_valid, mce_deliver, protected_mode, paging_active, dir_cache_allowed;
   logic dir_write_through_en, v86_ext_en, pm_virq_en, large_page_en, long_mode_allowed;
   logic tlb_flush, tlb_keep_global;
   logic [1:0] req_priv, dec_priv;
   logic [5:0] phys_addr_bits;
   logic [31:0] cr_wr_data, cr_rd_data, sys_m, pdb_m, feat_m, d;
   cff_sel_t cr_wr_sel, cr_rd_sel;
   cff_op_t req_op, dec_op;
   cff_verdict_t verdict;
   int n_errors, check_count;

   cff_ctrl u_dut (.clk_sys, .rst, .cr_wr_en, .cr_wr_sel, .cr_wr_data, .cr_rd_sel, .cr_rd_data,
      .cr_wr_fault, .task_switch_done(tsw), .dec_valid, .dec_op, .dec_priv, .mce_event,
      .verdict_valid, .verdict, .mce_deliver, .protected_mode, .paging_active, .dir_cache_allowed,
      .dir_write_through_en, .v86_ext_en, .pm_virq_en, .large_page_en, .phys_addr_bits,
      .long_mode_allowed, .tlb_flush, .tlb_keep_global);
   cff_decode_model u_dec (.clk_sys, .req_valid, .req_op, .req_priv, .dec_valid, .dec_op,
      .dec_priv);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic cff_verdict_t exp_v(input cff_op_t op, input logic [1:0] pv);
      logic em, ts, user;
      em = sys_m[CFF_NO_FPU_PRESENT];
      ts = sys_m[CFF_TASK_SWITCHED];
      user = pv != CFF_PRIV_KERNEL;
      case (op)
         CFF_OP_FLOAT: return (em || ts) ? CFF_V_DEV_UNAVAIL : CFF_V_EXECUTE;
         CFF_OP_FPU_WAIT: return (sys_m[CFF_MONITOR_COPROCESSOR] && ts) ? CFF_V_DEV_UNAVAIL
            : CFF_V_EXECUTE;
         CFF_OP_INT_SIMD, CFF_OP_STREAM_SIMD: return em ? CFF_V_INVALID_OP
            : ts ? CFF_V_DEV_UNAVAIL : CFF_V_EXECUTE;
         CFF_OP_READ_TIMESTAMP: return (feat_m[2] && user) ? CFF_V_GEN_PROT : CFF_V_EXECUTE;
         CFF_OP_READ_PERFCTR: return (!feat_m[8] && user) ? CFF_V_GEN_PROT : CFF_V_EXECUTE;
         CFF_OP_DEBUG_ALIAS: return feat_m[3] ? CFF_V_INVALID_OP : CFF_V_EXECUTE;
         CFF_OP_CTRL_REG, CFF_OP_CLEAR_TASK_FLAG: return (sys_m[0] && user) ? CFF_V_GEN_PROT
            : CFF_V_EXECUTE;
         default: return CFF_V_EXECUTE;
      endcase
   endfunction : exp_v

   task automatic wr(input cff_sel_t sel, input logic [31:0] v);
      logic flt;
      flt = sel == CFF_SEL_SYS && v[31] && !v[0];
      @(posedge clk_sys);
      cr_wr_en <= 1'b1;
      cr_wr_sel <= sel;
      cr_wr_data <= v;
      @(posedge clk_sys);
      cr_wr_en <= 1'b0;
      #1;
      chk("write fault", 32'(flt), 32'(cr_wr_fault));
      if (sel == CFF_SEL_SYS && !flt) sys_m = v & CFF_SYS_WMASK;
      if (sel == CFF_SEL_PDB) pdb_m = v & CFF_PDB_WMASK;
      if (sel == CFF_SEL_FEAT) feat_m = v & CFF_FEAT_WMASK;
   endtask : wr

   task automatic rd(input cff_sel_t sel, input logic [31:0] exp);
      @(posedge clk_sys);
      cr_rd_sel <= sel;
      @(posedge clk_sys);
      #1;
      chk(sel.name(), exp, cr_rd_data);
   endtask : rd

   task automatic run(input cff_op_t op, input logic [1:0] pv);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op <= op;
      req_priv <= pv;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("verdict valid", 32'h1, 32'(verdict_valid));
      chk(op.name(), 32'(exp_v(op, pv)), 32'(verdict));
      if (op == CFF_OP_CLEAR_TASK_FLAG) sys_m[CFF_TASK_SWITCHED] = 1'b0;
   endtask : run

   task automatic pulse(input logic sw);
      @(posedge clk_sys);
      tsw <= sw;
      mce_event <= !sw;
      @(posedge clk_sys);
      tsw <= 1'b0;
      mce_event <= 1'b0;
      #1;
      if (sw) begin
         chk("flush", 32'h1, 32'(tlb_flush));
         chk("keep global", 32'(feat_m[CFF_GLOBAL_PAGE_ON]), 32'(tlb_keep_global));
         sys_m[CFF_TASK_SWITCHED] = 1'b1;
      end else begin
         chk("machine check", 32'(feat_m[CFF_MACHINE_CHECK_ON]), 32'(mce_deliver));
      end
   endtask : pulse

   task automatic regs_and_modes;
      logic pg, cd;
      pg = sys_m[CFF_PAGING_ON];
      cd = sys_m[CFF_CACHE_OFF];
      rd(CFF_SEL_NONE, 32'h0);
      rd(CFF_SEL_PDB, pdb_m);
      rd(CFF_SEL_FEAT, feat_m);
      rd(CFF_SEL_SYS, sys_m);
      chk("paging", {30'h0, sys_m[0] & pg, sys_m[0]}, {30'h0, paging_active, protected_mode});
      chk("dir cache", 32'(!(pg && !cd && pdb_m[4])), 32'(dir_cache_allowed));
      chk("dir write through", 32'(pg && !cd && pdb_m[3]), 32'(dir_write_through_en));
      chk("features", {28'h0, feat_m[5:4], feat_m[1:0]},
         {28'h0, long_mode_allowed, large_page_en, pm_virq_en, v86_ext_en});
      chk("addr bits", feat_m[5] ? 32'h24 : 32'h20, 32'(phys_addr_bits));
   endtask : regs_and_modes

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end

   initial begin
      {rst, cr_wr_en, tsw, mce_event, req_valid} = 5'h10;
      cr_wr_sel = CFF_SEL_NONE;
      cr_rd_sel = CFF_SEL_NONE;
      cr_wr_data = 32'h0;
      req_op = CFF_OP_OTHER;
      req_priv = 2'h0;
      {sys_m, pdb_m, feat_m, d} = 128'h0;
      n_errors = 0;
      check_count = 0;
      void'($urandom(31742));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("reset outputs", 32'h41, {25'h0, phys_addr_bits, dir_cache_allowed});
      regs_and_modes();
      wr(CFF_SEL_SYS, 32'h8000_0000);
      wr(CFF_SEL_SYS, 32'hffff_ffff);
      wr(CFF_SEL_FEAT, 32'hffff_ffff);
      wr(CFF_SEL_PDB, 32'hffff_ffff);
      regs_and_modes();
      $display("test corner done");
      for (int i = 0; i < 30; i++) begin
         wr(CFF_SEL_SYS, $urandom());
         wr(CFF_SEL_PDB, $urandom());
         d = $urandom();
         if (!sys_m[CFF_PAGING_ON]) d[CFF_GLOBAL_PAGE_ON] = 1'b0;
         wr(i == 3 ? CFF_SEL_NONE : CFF_SEL_FEAT, d);
         regs_and_modes();
         if (d[9]) pulse(1'b1);
         pulse(1'b0);
         for (int k = 0; k <= 10; k++) run(cff_op_t'(k), 2'($urandom()));
         $display("test %0d done", i);
      end
      summarize();
   end
endmodule : coproc_and_feature_flag_control_test
`default_nettype wire
